// *** fcpc_pin_ctrl.sv ***
`timescale 1ns/10ps
`include "fcpc_defines.svh"
// Notes on behaviour
// RQ1 - Done pin open drain, released when finished
// RQ2 - Done pin held low keeps user mode off
// RQ3 - Reconfigure on reconfig pin rising edge only
// RQ4 - Test port samples inputs on clock rise
// RQ5 - Test output changes after test clock fall
// RQ6 - Controller changes test inputs after falling edge
// RQ7 - Undriven test inputs read as one
// RQ8 - Shift through instruction or selected data register
// RQ9 - Test output floats when not shifting
// RQ10 - Dedicated pins never become user I/O
// RQ11 - Three-bit width select picks data width
// RQ12 - Image select used when multi-image enabled
// RQ13 - Data line roles by serial mode, width
// RQ14 - Config clock input passive, output active
// RQ15 - Chip select low ignores configuration
// RQ16 - Select output enables next chained device
// RQ17 - Error pin low on ID, CRC, update
// RQ18 - Small package error means ID mismatch only
// RQ19 - Slave select sampled at reset release
// RQ20 - Test mode pin kept high during configuration
// RQ21 - Dual-purpose pins released in user mode
// RQ22 - Small package reserved output high while configuring
// RQ23 - Selections captured once, held until reconfiguration
module fcpc_pin_ctrl #(
  parameter int FIFO_DEPTH = `FCPC_FIFO_DEPTH,
  parameter int ACT_HALF = `FCPC_ACT_HALF_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic cresetN,
  input wire logic configCompleteIn,
  output logic configCompleteOut,
  output logic configCompleteOe,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdoOut,
  output logic tdoOe,
  input wire logic [2:0] cfgWidthSel,
  input wire logic [1:0] imageSel,
  input wire logic multiImageEn,
  input wire logic smallPackage,
  input wire logic chipSelIn,
  input wire logic cfgClkIn,
  output logic cfgClkOut,
  output logic cfgClkOe,
  input wire logic [31:0] cfgDataIn,
  output logic [31:0] cfgDataOut,
  output logic [31:0] cfgDataOe,
  input wire logic slaveSelIn,
  output logic slaveSelOut,
  output logic slaveSelOe,
  output logic cfgSelectOut,
  output logic cfgErrorN,
  output logic reservedOut,
  input wire fcpc_pkg::fcpc_err_type loadErr,
  input wire logic loadDone,
  output logic [31:0] wordData,
  output logic wordValid,
  input wire logic wordReady,
  output logic userMode,
  output logic loading,
  output logic [1:0] imageSelected
);
  logic [`FCPC_SYNC_BITS-1:0] pinSync;
  logic cresetS, tckS, tmsS, tdiS, doneS, chipSelS, cclkS, slaveSelS;
  logic [2:0] widthS;
  logic [1:0] imageS;
  logic [31:0] dataS;
  logic cresetD_reg, tckD_reg, cclkD_reg;
  logic cresetRise, tckRise, tckFall, cclkRise;
  fcpc_pkg::fcpc_cfg_state_type cfgState_reg, cfgState_next;
  fcpc_pkg::fcpc_mode_type mode_reg;
  fcpc_pkg::fcpc_tap_state_type tapState_reg, tapState_next;
  logic [`FCPC_IR_LEN-1:0] irShift_reg, irActive_reg;
  logic [31:0] dr_reg;
  logic [7:0] halfCnt_reg;
  logic actRise, stall, beat, errHit;
  logic [5:0] beatCnt_reg, beatLast, shamt;
  logic [31:0] lineMask, lines, word_reg, word_next;
  logic pushValid_reg, fifoReady;
  logic [31:0] pushData_reg;

  initial begin
    if (FIFO_DEPTH < 2) $error("fcpc_pin_ctrl: FIFO_DEPTH below 2");
    if (ACT_HALF < 1 || ACT_HALF > 255) $error("fcpc_pin_ctrl: ACT_HALF out of range");
  end

  // Undriven TMS and TDI pads are pulled up and therefore arrive as one. [RQ7]
  fcpc_sync #(.W(`FCPC_SYNC_BITS)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .d({cresetN, tck, tms, tdi, configCompleteIn, chipSelIn, cfgClkIn, slaveSelIn,
        cfgWidthSel, imageSel, cfgDataIn}),
    .q(pinSync)
  );
  assign {cresetS, tckS, tmsS, tdiS, doneS, chipSelS, cclkS, slaveSelS,
          widthS, imageS, dataS} = pinSync;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cresetD_reg <= 1'b0;
      tckD_reg <= 1'b0;
      cclkD_reg <= 1'b1;
    end else if (clkEn) begin
      cresetD_reg <= cresetS;
      tckD_reg <= tckS;
      cclkD_reg <= cclkS;
    end
  end
  assign cresetRise = cresetS && !cresetD_reg;
  assign tckRise = tckS && !tckD_reg;
  assign tckFall = !tckS && tckD_reg;
  assign cclkRise = cclkS && !cclkD_reg;

  // Reconfiguration starts on the release edge; the test port is untouched. [RQ3]
  always_comb begin
    errHit = smallPackage ? loadErr.idMismatch  // [RQ18]
                          : |loadErr;           // [RQ17]
    cfgState_next = cfgState_reg;
    case (cfgState_reg)
      fcpc_pkg::CFG_HOLD: if (cresetRise) cfgState_next = fcpc_pkg::CFG_LOAD; // [RQ3]
      fcpc_pkg::CFG_LOAD: begin
        if (errHit) cfgState_next = fcpc_pkg::CFG_FAIL;
        else if (loadDone) cfgState_next = fcpc_pkg::CFG_DONE_WAIT;
      end
      // User mode waits until the shared done line really reads high. [RQ2]
      fcpc_pkg::CFG_DONE_WAIT: if (doneS) cfgState_next = fcpc_pkg::CFG_USER;
      fcpc_pkg::CFG_USER: if (!doneS) cfgState_next = fcpc_pkg::CFG_DONE_WAIT; // [RQ2]
      fcpc_pkg::CFG_FAIL: cfgState_next = fcpc_pkg::CFG_FAIL;
      default: cfgState_next = fcpc_pkg::CFG_HOLD;
    endcase
    if (!cresetS) cfgState_next = fcpc_pkg::CFG_HOLD;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cfgState_reg <= fcpc_pkg::CFG_HOLD;
    else if (clkEn) cfgState_reg <= cfgState_next;
  end

  // Mode pins are caught once on release and held until the next one. [RQ19] [RQ23]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= '0;
      imageSelected <= 2'h0;
    end else if (clkEn && cresetRise && cfgState_reg == fcpc_pkg::CFG_HOLD) begin
      mode_reg.active <= slaveSelS;                         // [RQ19]
      mode_reg.width <= widthS;                             // [RQ11]
      mode_reg.image <= multiImageEn ? imageS : 2'h0;       // [RQ12]
      imageSelected <= multiImageEn ? imageS : 2'h0;        // [RQ12]
    end
  end

  // Status pins follow the next state so they align with it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      configCompleteOut <= 1'b0;
      configCompleteOe <= 1'b0;
      cfgErrorN <= 1'b1;
      cfgSelectOut <= 1'b0;
      reservedOut <= 1'b0;
      userMode <= 1'b0;
      loading <= 1'b0;
    end else if (clkEn) begin
      configCompleteOut <= 1'b0;                                            // [RQ1]
      configCompleteOe <= cfgState_next inside {fcpc_pkg::CFG_DONE_WAIT,
                                                fcpc_pkg::CFG_USER};        // [RQ1]
      cfgErrorN <= cfgState_next != fcpc_pkg::CFG_FAIL;                     // [RQ17]
      cfgSelectOut <= cfgState_next inside {fcpc_pkg::CFG_DONE_WAIT,
                                            fcpc_pkg::CFG_USER};            // [RQ16]
      reservedOut <= smallPackage && cfgState_next != fcpc_pkg::CFG_USER;  // [RQ22]
      userMode <= cfgState_next == fcpc_pkg::CFG_USER;
      loading <= cfgState_next == fcpc_pkg::CFG_LOAD;
    end
  end

  // Active mode divides the system clock and pauses while the FIFO is full.
  assign stall = pushValid_reg || !fifoReady;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halfCnt_reg <= 8'h00;
      cfgClkOut <= 1'b1;
    end else if (clkEn) begin
      if (!(loading && mode_reg.active && chipSelS)) begin
        halfCnt_reg <= 8'h00;
        cfgClkOut <= 1'b1;
      end else if (!(stall && !cfgClkOut)) begin
        if (halfCnt_reg == 8'(ACT_HALF - 1)) begin
          halfCnt_reg <= 8'h00;
          cfgClkOut <= !cfgClkOut;
        end else begin
          halfCnt_reg <= halfCnt_reg + 8'h01;
        end
      end
    end
  end
  assign actRise = !cfgClkOut && halfCnt_reg == 8'(ACT_HALF - 1) && !stall;

  // Chip select low means no beat is ever taken. [RQ15] [RQ14]
  assign beat = loading && chipSelS && !stall && (mode_reg.active ? actRise : cclkRise);

  always_comb begin
    case (mode_reg.width)
      `FCPC_WIDTH_X1: begin shamt = 6'h01; lineMask = 32'h0000_0001; end
      `FCPC_WIDTH_X2: begin shamt = 6'h02; lineMask = 32'h0000_0003; end
      `FCPC_WIDTH_X4: begin shamt = 6'h04; lineMask = 32'h0000_000f; end
      `FCPC_WIDTH_X8: begin shamt = 6'h08; lineMask = 32'h0000_00ff; end
      default: begin shamt = 6'h20; lineMask = 32'hffff_ffff; end
    endcase
    beatLast = 6'(`FCPC_WORD_BITS / shamt - 1);
    // Serial input is line 0 when passive, line 1 when active. [RQ13]
    if (mode_reg.width == `FCPC_WIDTH_X1) lines = {31'h0, mode_reg.active ? dataS[1] : dataS[0]};
    else lines = dataS & lineMask;
    word_next = (shamt == 6'h20) ? lines : ((word_reg << shamt) | lines);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_reg <= 32'h0000_0000;
      beatCnt_reg <= 6'h00;
      pushValid_reg <= 1'b0;
      pushData_reg <= 32'h0000_0000;
    end else if (clkEn) begin
      pushValid_reg <= pushValid_reg && !fifoReady;
      if (!loading) begin
        beatCnt_reg <= 6'h00;
      end else if (beat) begin
        word_reg <= word_next;
        beatCnt_reg <= (beatCnt_reg == beatLast) ? 6'h00 : beatCnt_reg + 6'h01;
        if (beatCnt_reg == beatLast) begin
          pushValid_reg <= 1'b1;
          pushData_reg <= word_next;
        end
      end
    end
  end

  fcpc_fifo #(.WIDTH(`FCPC_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .inValid(pushValid_reg),
    .inReady(fifoReady),
    .inData(pushData_reg),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordData)
  );

  // Dual-purpose pins drive only while loading and float in user mode. [RQ21]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgClkOe <= 1'b1;
      slaveSelOut <= 1'b1;
      slaveSelOe <= 1'b1;
      cfgDataOut <= 32'h0000_0000;
      cfgDataOe <= 32'hffff_ffff;
    end else if (clkEn) begin
      cfgClkOe <= !(loading && mode_reg.active);              // [RQ14]
      slaveSelOut <= !(loading && mode_reg.active);           // [RQ19]
      slaveSelOe <= !(loading && mode_reg.active);            // [RQ19]
      cfgDataOe <= 32'hffff_ffff;
      if (loading && mode_reg.width == `FCPC_WIDTH_X1) begin
        // Serial line 0 drives when active, line 1 echoes when passive. [RQ13]
        if (mode_reg.active) begin
          cfgDataOe[0] <= 1'b0;
          cfgDataOut[0] <= 1'b0;
        end else begin
          cfgDataOe[1] <= 1'b0;
          if (beat) cfgDataOut[1] <= dataS[0];
        end
      end
    end
  end

  // The test port stays on its own pins in every state. [RQ10]
  function automatic fcpc_pkg::fcpc_tap_state_type tapStep(
    input fcpc_pkg::fcpc_tap_state_type s, input logic m);
    case (s)
      fcpc_pkg::TAP_RESET: tapStep = m ? fcpc_pkg::TAP_RESET : fcpc_pkg::TAP_IDLE;
      fcpc_pkg::TAP_IDLE: tapStep = m ? fcpc_pkg::TAP_SEL_DR : fcpc_pkg::TAP_IDLE;
      fcpc_pkg::TAP_SEL_DR: tapStep = m ? fcpc_pkg::TAP_SEL_IR : fcpc_pkg::TAP_CAP_DR;
      fcpc_pkg::TAP_CAP_DR: tapStep = m ? fcpc_pkg::TAP_EXIT1_DR : fcpc_pkg::TAP_SHIFT_DR;
      fcpc_pkg::TAP_SHIFT_DR: tapStep = m ? fcpc_pkg::TAP_EXIT1_DR : fcpc_pkg::TAP_SHIFT_DR;
      fcpc_pkg::TAP_EXIT1_DR: tapStep = m ? fcpc_pkg::TAP_UPD_DR : fcpc_pkg::TAP_PAUSE_DR;
      fcpc_pkg::TAP_PAUSE_DR: tapStep = m ? fcpc_pkg::TAP_EXIT2_DR : fcpc_pkg::TAP_PAUSE_DR;
      fcpc_pkg::TAP_EXIT2_DR: tapStep = m ? fcpc_pkg::TAP_UPD_DR : fcpc_pkg::TAP_SHIFT_DR;
      fcpc_pkg::TAP_UPD_DR: tapStep = m ? fcpc_pkg::TAP_SEL_DR : fcpc_pkg::TAP_IDLE;
      fcpc_pkg::TAP_SEL_IR: tapStep = m ? fcpc_pkg::TAP_RESET : fcpc_pkg::TAP_CAP_IR;
      fcpc_pkg::TAP_CAP_IR: tapStep = m ? fcpc_pkg::TAP_EXIT1_IR : fcpc_pkg::TAP_SHIFT_IR;
      fcpc_pkg::TAP_SHIFT_IR: tapStep = m ? fcpc_pkg::TAP_EXIT1_IR : fcpc_pkg::TAP_SHIFT_IR;
      fcpc_pkg::TAP_EXIT1_IR: tapStep = m ? fcpc_pkg::TAP_UPD_IR : fcpc_pkg::TAP_PAUSE_IR;
      fcpc_pkg::TAP_PAUSE_IR: tapStep = m ? fcpc_pkg::TAP_EXIT2_IR : fcpc_pkg::TAP_PAUSE_IR;
      fcpc_pkg::TAP_EXIT2_IR: tapStep = m ? fcpc_pkg::TAP_UPD_IR : fcpc_pkg::TAP_SHIFT_IR;
      fcpc_pkg::TAP_UPD_IR: tapStep = m ? fcpc_pkg::TAP_SEL_DR : fcpc_pkg::TAP_IDLE;
      default: tapStep = fcpc_pkg::TAP_RESET;
    endcase
  endfunction
  assign tapState_next = tapStep(tapState_reg, tmsS);

  // Inputs are taken on the rising test clock edge. [RQ4] [RQ6]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tapState_reg <= fcpc_pkg::TAP_RESET;
      irShift_reg <= `FCPC_IR_CAPTURE;
      irActive_reg <= `FCPC_OP_IDCODE;
      dr_reg <= 32'h0000_0000;
    end else if (clkEn && tckRise) begin
      tapState_reg <= tapState_next;                                         // [RQ4]
      case (tapState_reg)
        fcpc_pkg::TAP_RESET: irActive_reg <= `FCPC_OP_IDCODE;
        fcpc_pkg::TAP_CAP_IR: irShift_reg <= `FCPC_IR_CAPTURE;
        fcpc_pkg::TAP_SHIFT_IR: irShift_reg <= {tdiS, irShift_reg[`FCPC_IR_LEN-1:1]}; // [RQ8]
        fcpc_pkg::TAP_UPD_IR: irActive_reg <= irShift_reg;
        fcpc_pkg::TAP_CAP_DR:
          dr_reg <= (irActive_reg == `FCPC_OP_IDCODE) ? `FCPC_ID_VALUE : 32'h0000_0000;
        fcpc_pkg::TAP_SHIFT_DR: begin
          // Identification path is 32 bits long, every other one a single bit. [RQ8]
          if (irActive_reg == `FCPC_OP_IDCODE) dr_reg <= {tdiS, dr_reg[31:1]};
          else dr_reg <= {31'h0, tdiS};
        end
        default: dr_reg <= dr_reg;
      endcase
    end
  end

  // Output moves on the falling edge and floats outside shift states. [RQ5] [RQ9]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdoOut <= 1'b0;
      tdoOe <= 1'b1;
    end else if (clkEn && tckFall) begin
      tdoOut <= (tapState_reg == fcpc_pkg::TAP_SHIFT_IR) ? irShift_reg[0] : dr_reg[0]; // [RQ5]
      tdoOe <= !(tapState_reg inside {fcpc_pkg::TAP_SHIFT_IR, fcpc_pkg::TAP_SHIFT_DR}); // [RQ9]
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_release;
    clkEn && cresetRise && cfgState_reg == fcpc_pkg::CFG_HOLD;
  endsequence
  sequence s_loading_starts;
    loading && !userMode;
  endsequence

  a_done_open_drain: assert property (configCompleteOut == 1'b0 &&
    (configCompleteOe || !userMode)) else $error("done pin driven high"); // [RQ1]
  a_user_needs_done: assert property ($rose(userMode) |-> $past(doneS))
    else $error("user mode without done high"); // [RQ2]
  a_reconfig_release: assert property (s_release |=> s_loading_starts)
    else $error("reconfiguration did not start"); // [RQ3]
  a_tdo_on_fall: assert property (!$stable(tdoOut) |-> $past(tckFall && clkEn))
    else $error("test output moved off falling edge"); // [RQ5]
  a_tdo_idle_float: assert property (clkEn && tckFall && !(tapState_reg inside
    {fcpc_pkg::TAP_SHIFT_IR, fcpc_pkg::TAP_SHIFT_DR}) |=> tdoOe)
    else $error("test output driven outside shift"); // [RQ9]
  a_mode_held_load: assert property (loading && $past(loading) |-> $stable(mode_reg))
    else $error("mode changed during load"); // [RQ23]
  a_error_on_id: assert property (clkEn && cresetS && cfgState_reg == fcpc_pkg::CFG_LOAD &&
    loadErr.idMismatch |=> !cfgErrorN) else $error("error pin not low on mismatch"); // [RQ17]
  a_small_pkg_err: assert property ($fell(cfgErrorN) && smallPackage |->
    $past(loadErr.idMismatch)) else $error("small package error without mismatch"); // [RQ18]
  a_cclk_driven: assert property (loading && mode_reg.active && $past(loading) |-> !cfgClkOe)
    else $error("config clock not driven in active mode"); // [RQ14]
  a_no_beat_unsel: assert property (!chipSelS |=> $stable(word_reg))
    else $error("beat taken while deselected"); // [RQ15]
endmodule

// *** fcpc_defines.svh ***
`ifndef FCPC_DEFINES_SVH
`define FCPC_DEFINES_SVH
`define FCPC_CLK_NS 50
`define FCPC_ACT_HALF_NS 100
`define FCPC_ACT_HALF_CYC ((`FCPC_ACT_HALF_NS + `FCPC_CLK_NS - 1) / `FCPC_CLK_NS)
`define FCPC_WORD_BITS 32
`define FCPC_FIFO_DEPTH 4
`define FCPC_SYNC_BITS 45
`define FCPC_IR_LEN 4
`define FCPC_IR_CAPTURE 4'h1
`define FCPC_OP_IDCODE 4'h3
`define FCPC_OP_BYPASS 4'hf
// Identification value is arbitrary; bit 0 stays set as test ports expect.
`define FCPC_ID_VALUE 32'h0a5c_0001
`define FCPC_WIDTH_X1 3'h0
`define FCPC_WIDTH_X2 3'h1
`define FCPC_WIDTH_X4 3'h2
`define FCPC_WIDTH_X8 3'h3
`endif

// *** fcpc_pkg.sv ***
package fcpc_pkg;
  typedef enum logic [2:0] {
    CFG_HOLD, CFG_LOAD, CFG_DONE_WAIT, CFG_USER, CFG_FAIL
  } fcpc_cfg_state_type;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } fcpc_tap_state_type;
  typedef struct packed {
    logic active;
    logic [2:0] width;
    logic [1:0] image;
  } fcpc_mode_type;
  typedef struct packed {
    logic idMismatch;
    logic crcFail;
    logic updateFail;
  } fcpc_err_type;
endpackage

// *** fcpc_sync.sv ***
`timescale 1ns/10ps
module fcpc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) $error("fcpc_sync: W must be at least 1");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q <= '0;
    end else if (clkEn) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// *** fcpc_fifo.sv ***
`timescale 1ns/10ps
module fcpc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("fcpc_fifo: DEPTH >= 2 and WIDTH >= 1 needed");
  end

  // Slot 0 is always the head, so the output data is a flip-flop.
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always_comb begin
    count_next = count_reg;
    if (push && !pop) count_next = count_reg + CW'(1);
    if (pop && !push) count_next = count_reg - CW'(1);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
    end else if (clkEn) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) mem_reg[i] <= (i == DEPTH - 1) ? '0 : mem_reg[i+1];
        if (push && CW'(i) == count_reg - CW'(pop)) mem_reg[i] <= inData;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end else if (clkEn) begin
      count_reg <= count_next;
      inReady <= count_next != CW'(DEPTH);
      outValid <= count_next != '0;
    end
  end
  assign outData = mem_reg[0];
endmodule

// *** fcpc_host_model.sv ***
`timescale 1ns/10ps
module fcpc_host_model (
  output logic cfgClk,
  output logic [31:0] cfgData
);
  initial begin
    cfgClk = 1'b0;
    cfgData = 32'h0;
  end
  // Sends one full word as a single beat; the clock rests low between beats.
  task automatic send_word(input logic [31:0] w);
    cfgData = w;
    #200 cfgClk = 1'b1;
    #200 cfgClk = 1'b0;
    #50 cfgData = ~w;
  endtask
endmodule

// *** tb_fcpc_pin_ctrl.sv ***
`timescale 1ns/10ps
`include "fcpc_defines.svh"
module tb_fcpc_pin_ctrl;
  logic clk, rstn, cresetN, doneHoldLow, tck, tms, tdi, multiImageEn, smallPackage;
  logic chipSelIn, slaveSelDrv, loadDone, wordReady, doneWire, clkWire, ssWire, wordValid;
  logic configCompleteOut, configCompleteOe, tdoOut, tdoOe, cfgClkOut, cfgClkOe, hostClk;
  logic slaveSelOut, slaveSelOe, cfgSelectOut, cfgErrorN, reservedOut, userMode, loading;
  logic [2:0] cfgWidthSel;
  logic [1:0] imageSel, imageSelected, imgExp;
  logic [31:0] hostData, dataWire, cfgDataOut, cfgDataOe, wordData, tdoWord, w;
  fcpc_pkg::fcpc_err_type loadErr;
  logic [31:0] expWords[$];
  int badCount, cmpCount;
  assign doneWire = (configCompleteOe === 1'b0) ? configCompleteOut : !doneHoldLow;
  assign clkWire = cfgClkOe ? hostClk : cfgClkOut;
  assign ssWire = slaveSelOe ? slaveSelDrv : slaveSelOut;
  assign dataWire = (cfgDataOe & hostData) | (~cfgDataOe & cfgDataOut);
  fcpc_host_model host (.cfgClk(hostClk), .cfgData(hostData));
  fcpc_pin_ctrl dut (.clk(clk), .rstn(rstn), .clkEn(1'b1), .cresetN(cresetN),
    .configCompleteIn(doneWire), .configCompleteOut(configCompleteOut),
    .configCompleteOe(configCompleteOe), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut),
    .tdoOe(tdoOe), .cfgWidthSel(cfgWidthSel), .imageSel(imageSel), .multiImageEn(multiImageEn),
    .smallPackage(smallPackage), .chipSelIn(chipSelIn), .cfgClkIn(clkWire),
    .cfgClkOut(cfgClkOut), .cfgClkOe(cfgClkOe), .cfgDataIn(dataWire), .cfgDataOut(cfgDataOut),
    .cfgDataOe(cfgDataOe), .slaveSelIn(ssWire), .slaveSelOut(slaveSelOut),
    .slaveSelOe(slaveSelOe), .cfgSelectOut(cfgSelectOut), .cfgErrorN(cfgErrorN),
    .reservedOut(reservedOut), .loadErr(loadErr), .loadDone(loadDone), .wordData(wordData),
    .wordValid(wordValid), .wordReady(wordReady), .userMode(userMode), .loading(loading),
    .imageSelected(imageSelected));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict;
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Low pulse on the reload pin, wait for loading, then turn the mode pin round.
  task automatic reconfig(input logic act);
    cresetN = 1'b0;
    slaveSelDrv = act;
    cyc(4);
    cresetN = 1'b1;
    for (int i = 0; i < 10 && loading !== 1'b1; i++) cyc(1);
    check(loading, 1'b1);
    slaveSelDrv = ~act;
  endtask
  // Test inputs change just after the falling test clock edge.
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    cyc(6);
    tdoWord = {tdoOut, tdoWord[31:1]};
    tck = 1'b1;
    cyc(6);
    tck = 1'b0;
  endtask
  always @(posedge clk) begin
    if (wordValid === 1'b1 && wordReady === 1'b1) begin
      if (expWords.size() == 0) check(32'(expWords.size()), 32'h1);
      else check(wordData, expWords.pop_front());
    end
  end
  initial begin
    #3000000;
    badCount++;
    giveVerdict;
  end
  initial begin
    rstn = 1'b0; cresetN = 1'b0; doneHoldLow = 1'b0; tck = 1'b0; tms = 1'b1; tdi = 1'b1;
    cfgWidthSel = 3'h4; imageSel = 2'h0; multiImageEn = 1'b1; smallPackage = 1'b1;
    chipSelIn = 1'b1; slaveSelDrv = 1'b0; loadDone = 1'b0; wordReady = 1'b0; loadErr = '0;
    badCount = 0; cmpCount = 0; tdoWord = 32'h0;
    void'($urandom(53));
    // The active-low test-mode pin is not a port here; the board keeps it high.
    cyc(3);
    rstn = 1'b1;
    check(doneWire, 1'b0);
    check(cfgErrorN, 1'b1);
    check(tdoOe, 1'b1);
    cfgWidthSel = 3'h4 | 3'($urandom % 4);
    imgExp = 2'($urandom);
    imageSel = imgExp;
    reconfig(1'b0);
    check(imageSelected, imgExp);
    cfgWidthSel = 3'h0;
    imageSel = ~imgExp;
    check(reservedOut, 1'b1);
    check(cfgClkOe, 1'b1);
    // Five words against a four-deep buffer: the last one must be dropped.
    for (int i = 0; i < 5; i++) begin
      w = $urandom;
      if (i < 4) expWords.push_back(w);
      host.send_word(w);
      cyc(2);
    end
    check(wordValid, 1'b1);
    for (int i = 0; i < 40; i++) begin
      wordReady = 1'($urandom % 2);
      cyc(1);
    end
    wordReady = 1'b1;
    cyc(4);
    check(32'(expWords.size()), 32'h0);
    check(imageSelected, imgExp);
    chipSelIn = 1'b0;
    host.send_word($urandom);
    cyc(6);
    check(wordValid, 1'b0);
    chipSelIn = 1'b1;
    doneHoldLow = 1'b1;
    loadDone = 1'b1;
    cyc(1);
    loadDone = 1'b0;
    cyc(1);
    check(configCompleteOe, 1'b1);
    check(cfgSelectOut, 1'b1);
    cyc(8);
    check(userMode, 1'b0);
    doneHoldLow = 1'b0;
    cyc(5);
    check(userMode, 1'b1);
    check(reservedOut, 1'b0);
    check(cfgDataOe, 32'hffff_ffff);
    multiImageEn = 1'b0;
    imageSel = 2'h1 | 2'($urandom);
    reconfig(1'b0);
    check(imageSelected, 2'h0);
    loadErr.crcFail = 1'b1;
    cyc(3);
    check(cfgErrorN, 1'b1);
    loadErr.idMismatch = 1'b1;
    cyc(2);
    check(cfgErrorN, 1'b0);
    loadErr = '0;
    smallPackage = 1'b0;
    for (int k = 0; k < 3; k++) begin
      reconfig(1'b0);
      check(cfgErrorN, 1'b1);
      loadErr = 3'(1 << k);
      cyc(2);
      check(cfgErrorN, 1'b0);
      loadErr = '0;
    end
    wordReady = 1'b0;
    reconfig(1'b1);
    cyc(2);
    check(cfgClkOe, 1'b0);
    check(slaveSelOe, 1'b0);
    check(slaveSelOut, 1'b0);
    for (int i = 0; i < 5; i++) tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    check(tdoOe, 1'b1);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < 32; i++) begin
      tick(i == 31, 1'b1);
      if (i == 8) check(tdoOe, 1'b0);
    end
    check(tdoWord, `FCPC_ID_VALUE);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    check(tdoOe, 1'b1);
    // Instruction path: capture pattern out, bypass code in, then a one-bit data path.
    tick(1'b1, 1'b1);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    for (int i = 0; i < 4; i++) tick(i == 3, 1'b1);
    check(tdoWord[31:28], `FCPC_IR_CAPTURE);
    tick(1'b1, 1'b1);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b0, 1'b1);
    tick(1'b1, 1'b1);
    check(tdoWord[31:30], 2'h2);
    // The active load has filled the buffer by now, so its clock rests low.
    cyc(10);
    check(cfgClkOut, 1'b0);
    check(wordValid, 1'b1);
    check(cfgDataOe, 32'hffff_fffe);
    giveVerdict;
  end
endmodule
